/* common/dpst_pkg.sv */
// Functional notes
// R1: Allow 1024 cycles for initial calibration.
// R2: Long calibration 512, short calibration 128 cycles.
// R3: Command path disables 4 cycles after entry.
// R4: Power-saving entry waits update plus disable delay.
// R5: Power-saving exit follows self-refresh exit delays.
// R6: Reset exit waits max(5 cycles, refresh+10ns).
// R7: Self-refresh exit waits refresh+10ns, DLL lock.
// R8: Aborted self-refresh uses shorter exit delay.
// R9: Self-refresh clock-enable low lasts pulse plus one.
// R10: Clock stays valid around power-state changes.
// R11: Power-down exit waits max(4 cycles, 6ns).
// R12: Each clock-enable level lasts max(3 cycles, 5ns).
// R13: Power-down lasts pulse width, below nine intervals.
// R14: Activate, precharge, refresh need 2 cycles first.
// R15: Read needs read latency plus 5 first.
// R16: Write needs latency, burst, recovery cycles first.
// R17: Addressed mode-register writes spaced 16 cycles, 10ns.
// R18: Write leveling strobe waits 25, edge 40.
// R19: Parity error alert pulse lasts 56 to 128.
// R20: Alert asserts within parity latency plus 6ns.
// R21: Commands near parity error may be dropped.
// R22: Persistent parity: deselects within 57 cycles of alert.
// R23: Mode-register update delay is max(24 cycles, 15ns).
// R24: Controller counts each constraint before issuing. The model only counts CKE_HOLD_CYC deselects after a clock-enable change.
package dpst_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PAR_LAT_CYC = 4;
  localparam int ALERT_ON_EXTRA_NS = 6;
  localparam int ALERT_ON_EXTRA_RAW = (ALERT_ON_EXTRA_NS * 1000) / CLK_PERIOD_PS;
  localparam int ALERT_ON_EXTRA_CYC = (ALERT_ON_EXTRA_RAW < 1) ? 1 : ALERT_ON_EXTRA_RAW;
  localparam int ALERT_ON_MAX_CYC = PAR_LAT_CYC + ALERT_ON_EXTRA_CYC;
  localparam int ALERT_PW_MIN_CYC = 56;
  localparam int ALERT_PW_MAX_CYC = 128;
  localparam logic [6:0] ALERT_PW_CYC = 7'h40;
  localparam logic [2:0] CPDED_CYC = 3'h4;
  localparam logic [2:0] PAR_BLANK_CYC = 3'h4;
  localparam logic [10:0] ZQ_INIT_CYC = 11'h400;
  localparam logic [10:0] ZQ_LONG_CYC = 11'h200;
  localparam logic [10:0] ZQ_SHORT_CYC = 11'h080;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_DESELECT = 3'h0;
  localparam logic [2:0] CMD_ZQ_LONG = 3'h2;
  localparam logic [2:0] CMD_ZQ_SHORT = 3'h3;
  localparam logic [2:0] CMD_MAX_POWER_SAVING_MODE_ENTER = 3'h4;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DRAIN = 2'b01,
    PWR_OFF = 2'b11
  } dpst_pwr_t;

endpackage : dpst_pkg

/* hw/dpst_alert_pulse.sv */
`timescale 1ns/1ps
module dpst_alert_pulse
  import dpst_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Trigger
  input wire logic trig_in,
  // Alert pin
  output logic alert_b_out
);

  logic [6:0] cnt_q;

  // ----------------------------------------------------------------
  // Alert pulse
  // ----------------------------------------------------------------
  // A trigger while the pulse runs is ignored; the pulse has a fixed width.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 7'h00;
      alert_b_out <= 1'b1;
    end else if (alert_b_out && trig_in) begin
      cnt_q <= ALERT_PW_CYC - 7'h01; // [R19]
      alert_b_out <= 1'b0; // [R20]
    end else if (!alert_b_out) begin
      if (cnt_q == 7'h00) begin
        alert_b_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end

endmodule : dpst_alert_pulse

/* hw/dpst_core.sv */
`timescale 1ns/1ps
module dpst_core
  import dpst_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Clock enable pin
  input wire logic cke_in,
  // Command stream
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  // Parity check
  input wire logic parity_en_in,
  input wire logic parity_err_in,
  input wire logic persist_par_in,
  // Executed command
  output logic cmd_exec_out,
  output logic [2:0] cmd_code_out,
  // Status
  output logic cmd_path_on_out,
  output logic zq_busy_out,
  output logic alert_b_out
);

  dpst_pwr_t pwr_q;
  logic cke_q;
  logic [2:0] drain_q;
  logic [2:0] blank_q;
  logic [10:0] zq_q;
  logic err_hit;
  logic accept;
  logic enter_req;

  // ----------------------------------------------------------------
  // Command qualification
  // ----------------------------------------------------------------
  always_comb begin
    err_hit = cmd_valid_in && parity_en_in && parity_err_in && (persist_par_in || alert_b_out);
    accept = cmd_valid_in && (cmd_code_in != CMD_DESELECT) && (pwr_q != PWR_OFF)
      && !err_hit && (blank_q == 3'h0); // [R21]
    enter_req = (cke_q && !cke_in) || (accept && (cmd_code_in == CMD_MAX_POWER_SAVING_MODE_ENTER));
  end

  // ----------------------------------------------------------------
  // Parity blanking window
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blank_q <= 3'h0;
    end else if (err_hit) begin
      blank_q <= PAR_BLANK_CYC; // [R21]
    end else if (blank_q != 3'h0) begin
      blank_q <= blank_q - 3'h1;
    end
  end

  dpst_alert_pulse u_alert (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .trig_in(err_hit),
    .alert_b_out(alert_b_out)
  );

  // ----------------------------------------------------------------
  // Power state and command path
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_q <= PWR_ACTIVE;
      drain_q <= 3'h0;
      cmd_path_on_out <= 1'b1;
    end else begin
      case (pwr_q)
        PWR_ACTIVE: begin
          if (enter_req) begin
            pwr_q <= PWR_DRAIN;
            drain_q <= CPDED_CYC - 3'h1; // [R3]
          end
        end
        PWR_DRAIN: begin
          if (drain_q == 3'h0) begin
            pwr_q <= PWR_OFF; // [R3]
            cmd_path_on_out <= 1'b0;
          end else begin
            drain_q <= drain_q - 3'h1;
          end
        end
        PWR_OFF: begin
          if (cke_in && !cke_q) begin
            pwr_q <= PWR_ACTIVE;
            cmd_path_on_out <= 1'b1;
          end
        end
        default: begin
          pwr_q <= PWR_ACTIVE;
          cmd_path_on_out <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Calibration busy
  // ----------------------------------------------------------------
  // The initial calibration runs from reset release; later requests are
  // ignored while one is still running.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      zq_q <= ZQ_INIT_CYC;
      zq_busy_out <= 1'b1;
    end else if (zq_q != 11'h000) begin
      zq_q <= zq_q - 11'h001;
      zq_busy_out <= (zq_q != 11'h001);
    end else if (accept && (cmd_code_in == CMD_ZQ_LONG)) begin
      zq_q <= ZQ_LONG_CYC;
      zq_busy_out <= 1'b1;
    end else if (accept && (cmd_code_in == CMD_ZQ_SHORT)) begin
      zq_q <= ZQ_SHORT_CYC;
      zq_busy_out <= 1'b1;
    end else begin
      zq_busy_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Executed command output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_exec_out <= 1'b0;
      cmd_code_out <= CMD_DESELECT;
    end else begin
      cmd_exec_out <= accept;
      cmd_code_out <= accept ? cmd_code_in : CMD_DESELECT;
    end
  end

endmodule : dpst_core

/* testbench/dpst_props.sv */
`timescale 1ns/1ps
module dpst_props
  import dpst_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic cke_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic parity_en_in,
  input wire logic parity_err_in,
  input wire logic cmd_exec_out,
  input wire logic [2:0] cmd_code_out,
  input wire logic cmd_path_on_out,
  input wire logic alert_b_out
);
  logic [6:0] lo_q;
  wire hit = cmd_valid_in & parity_en_in & parity_err_in & alert_b_out;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_q <= 7'h00;
    end else begin
      lo_q <= alert_b_out ? 7'h00 : lo_q + 7'h01;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_drain;
    cmd_path_on_out [*4] ##1 !cmd_path_on_out;
  endsequence
  a_alert_width: assert property ($rose(alert_b_out) |-> lo_q == ALERT_PW_CYC)
    else $error("alert width");
  a_alert_delay: assert property (hit |=> !alert_b_out) else $error("alert late");
  a_par_blank: assert property (hit |=> !cmd_exec_out [*5]) else $error("blank");
  a_exec_code: assert property (cmd_exec_out |-> cmd_code_out == $past(cmd_code_in))
    else $error("exec code");
  a_cke_drain: assert property (cmd_path_on_out && $fell(cke_in) |-> ##1 s_drain)
    else $error("drain");
  a_entry_drain: assert property (cmd_exec_out && cmd_code_out == CMD_MAX_POWER_SAVING_MODE_ENTER |-> s_drain)
    else $error("entry drain");
  a_off_refuse: assert property (!cmd_path_on_out |=> !cmd_exec_out) else $error("off");
  a_path_exit: assert property (!cmd_path_on_out && $rose(cke_in) |=> cmd_path_on_out)
    else $error("exit");
endmodule : dpst_props
bind dpst_core dpst_props dpst_props_inst (.*);

/* testbench/dpst_ctrl_model.sv */
`timescale 1ns/1ps
module dpst_ctrl_model
  import dpst_pkg::*;
(
  input wire logic ref_clk_in,
  output logic cke_out = 1'b0,
  output logic valid_out = 1'b0,
  output logic [2:0] code_out = 3'h0,
  output logic err_out = 1'b0
);
  localparam int CKE_HOLD_CYC = 3;
  localparam int PD_EXIT_CYC = 4;
  localparam int PD_ENTRY_CYC = 2;
  localparam int MR_GAP_CYC = 24;
  localparam int DES_RESP_CYC = 57;
  task automatic cmd(input logic [2:0] c, input logic e);
    @(posedge ref_clk_in);
    valid_out <= c != CMD_DESELECT;
    code_out <= c;
    err_out <= e;
    #1;
  endtask : cmd
  task automatic cke(input logic v);
    @(posedge ref_clk_in);
    cke_out <= v;
    valid_out <= 1'b0;
    repeat (CKE_HOLD_CYC) cmd(CMD_DESELECT, 1'b0);
  endtask : cke
endmodule : dpst_ctrl_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import dpst_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cke, valid, err, path_on, busy, alert_b, exec;
  logic persist = 1'b0;
  logic [2:0] code, code_q;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  always #12.5 ref_clk_in = ~ref_clk_in;
  dpst_ctrl_model ctl (.ref_clk_in(ref_clk_in), .cke_out(cke), .valid_out(valid),
    .code_out(code), .err_out(err));
  dpst_core dpst_core_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cke_in(cke),
    .cmd_valid_in(valid), .cmd_code_in(code), .parity_en_in(1'b1), .parity_err_in(err),
    .persist_par_in(persist), .cmd_exec_out(exec), .cmd_code_out(code_q),
    .cmd_path_on_out(path_on), .zq_busy_out(busy), .alert_b_out(alert_b));
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Counts edges while the chosen status output keeps the given level.
  task automatic span(input logic alt, input logic lvl);
    n = 0;
    while ((alt ? alert_b : busy) === lvl && n < 2000) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
  endtask : span
  task automatic t_zq();
    span(1'b0, 1'b1);
    check("zq init", 11'(n), ZQ_INIT_CYC);
    for (int i = 0; i < 2; i++) begin
      ctl.cmd(i ? CMD_ZQ_LONG : CMD_ZQ_SHORT, 1'b0);
      ctl.cmd(3'h0, 1'b0);
      span(1'b0, 1'b1);
      check("zq span", 11'(n), i ? ZQ_LONG_CYC : ZQ_SHORT_CYC);
    end
  endtask : t_zq
  task automatic t_cmds();
    for (int i = 5; i < 8; i++) begin
      ctl.cmd(3'(i), 1'b0);
      ctl.cmd(3'h0, 1'b0);
      check("code", code_q, 11'(i));
      check("exec", exec, 11'h1);
    end
  endtask : t_cmds
  task automatic t_parity();
    @(posedge ref_clk_in);
    persist <= 1'b1;
    ctl.cmd(3'h1, 1'b1);
    for (int i = 1; i < 7; i++) begin
      ctl.cmd(3'h1, 1'b0);
      check("code", code_q, (i == 6) ? 11'h1 : 11'h0);
    end
    check("alert", alert_b, 11'h0);
    ctl.cmd(3'h1, 1'b1);
    ctl.cmd(3'h1, 1'b0);
    check("code", code_q, 11'h0);
    ctl.cmd(3'h0, 1'b0);
    span(1'b1, 1'b0);
    check("alert span", 11'(n), 11'(ALERT_PW_CYC) - 11'h8);
  endtask : t_parity
  task automatic t_power();
    ctl.cke(1'b1);
    ctl.cke(1'b0);
    check("path", path_on, 11'h1);
    repeat (2) ctl.cmd(3'h0, 1'b0);
    check("path", path_on, 11'h0);
    ctl.cmd(3'h1, 1'b0);
    ctl.cmd(3'h0, 1'b0);
    check("code", code_q, 11'h0);
    check("exec", exec, 11'h0);
    ctl.cke(1'b1);
    check("path", path_on, 11'h1);
    ctl.cmd(CMD_MAX_POWER_SAVING_MODE_ENTER, 1'b0);
    repeat (5) ctl.cmd(3'h0, 1'b0);
    check("path", path_on, 11'h0);
  endtask : t_power
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    #1;
    t_zq();
    t_cmds();
    t_parity();
    t_power();
    summarize();
  end
  initial begin
    repeat (4000) @(posedge ref_clk_in);
    error_cnt++;
    summarize();
  end
endmodule : testbench
